// [core/pfc_ctrl.sv]
// program flash write/erase control: register, move-write steering and flash strobes
`timescale 1ns/10ps
// What this block does
// - with write enable set and erase enable clear, move writes program the addressed flash byte
// - with erase and write enable set, move writes erase the addressed page
// - a page erase ignores the data byte of the move write
// - no erase without erase enable; no programming without write enable
// - upper six control bits unused, read zero; register resets to zero
module pfc_ctrl
  import pfc_pkg::*;
#(
  parameter int ADDR_W = pfc_pkg::PFC_ADDR_W,
  parameter int PAGE_BYTES = pfc_pkg::PFC_PAGE_BYTES
) (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic sfrWr, // special register write strobe
  input wire logic sfrRd, // special register read strobe
  input wire logic [7:0] sfrAddr, // special register address
  input wire logic [7:0] sfrWdata, // special register write data
  output logic [7:0] sfrRdata, // special register read data
  output logic sfrHit, // address selects the control register
  input wire logic moveWr, // external data move write strobe
  input wire logic [ADDR_W-1:0] moveAddr, // move write address
  input wire logic [7:0] moveData, // move write data byte
  output logic moveStall, // core must hold while flash is busy
  output logic ramWr, // write pulse to external data ram
  output logic [ADDR_W-1:0] ramAddr, // external data ram address
  output logic [7:0] ramData, // external data ram data
  output logic flashProg, // one-cycle byte program strobe
  output logic flashErase, // one-cycle page erase strobe
  output logic [ADDR_W-1:0] flashAddr, // byte address or page base
  output logic [7:0] flashData, // byte to program
  output logic flashBusy // flash operation in progress
);
  import pfc_pkg::*;

  // ****************************************
  // control register
  // ****************************************
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic ctrlSel;

  assign ctrlSel = (sfrAddr == PFC_CTRL_ADDR);
  assign sfrHit = ctrlSel;

  always_comb begin
    next_ctrl = ctrl;
    if (sfrWr && ctrlSel) begin
      next_ctrl = {sfrWdata[PFC_EE_BIT], sfrWdata[PFC_WE_BIT]};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= PFC_CTRL_RESET[1:0];
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // upper bits have no storage and read as zero
  assign sfrRdata = (sfrRd && ctrlSel) ? {6'h00, ctrl} : 8'h00;

  // ****************************************
  // move write steering
  // ****************************************
  function automatic logic [ADDR_W-1:0] pageBase(input logic [ADDR_W-1:0] a);
    return a & ~(ADDR_W'(PAGE_BYTES - 1));
  endfunction

  logic weOn;
  logic eeOn;
  pfc_op_t op;
  logic busy;
  logic accept;
  assign weOn = ctrl[PFC_WE_BIT];
  assign eeOn = ctrl[PFC_EE_BIT];
  assign moveStall = moveWr && busy;
  assign accept = moveWr && !busy;

  always_comb begin
    op = PFC_OP_NONE;
    if (weOn && eeOn) begin
      op = PFC_OP_ERASE;
    end else if (weOn) begin
      op = PFC_OP_PROG;
    end
  end

  logic next_ramWr;
  logic next_flashProg;
  logic next_flashErase;
  logic [ADDR_W-1:0] next_ramAddr;
  logic [ADDR_W-1:0] next_flashAddr;
  logic [7:0] next_ramData;
  logic [7:0] next_flashData;

  always_comb begin
    next_ramWr = 1'b0;
    next_flashProg = 1'b0;
    next_flashErase = 1'b0;
    next_ramAddr = ramAddr;
    next_ramData = ramData;
    next_flashAddr = flashAddr;
    next_flashData = flashData;
    if (accept) begin
      unique case (op)
        PFC_OP_NONE: begin
          next_ramWr = 1'b1;
          next_ramAddr = moveAddr;
          next_ramData = moveData;
        end
        PFC_OP_PROG: begin
          next_flashProg = 1'b1;
          next_flashAddr = moveAddr;
          next_flashData = moveData;
        end
        PFC_OP_ERASE: begin
          // data byte dropped so every value erases alike
          next_flashErase = 1'b1;
          next_flashAddr = pageBase(moveAddr);
          next_flashData = 8'h00;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramWr <= 1'b0;
      flashProg <= 1'b0;
      flashErase <= 1'b0;
      ramAddr <= '0;
      ramData <= 8'h00;
      flashAddr <= '0;
      flashData <= 8'h00;
    end else begin
      ramWr <= next_ramWr;
      flashProg <= next_flashProg;
      flashErase <= next_flashErase;
      ramAddr <= next_ramAddr;
      ramData <= next_ramData;
      flashAddr <= next_flashAddr;
      flashData <= next_flashData;
    end
  end

  // ****************************************
  // busy timing
  // ****************************************
  // busy starts on the strobe cycle so a back-to-back move write stalls
  logic tmrBusy;
  logic [7:0] tmrCycles;
  assign tmrCycles = flashErase ? 8'(PFC_ERASE_CYC) : 8'(PFC_PROG_CYC);

  pfc_flash_timer #(.CNT_W(8)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(flashProg || flashErase),
    .cycles(tmrCycles),
    .busy(tmrBusy)
  );

  assign busy = tmrBusy || flashProg || flashErase;
  assign flashBusy = busy;

  // ****************************************
  // checks
  // ****************************************
  chk_prog_needs_we: assert property (@(posedge mclk) disable iff (!rst_n)
    flashProg |-> $past(weOn) && !$past(eeOn))
    else $error("byte program without write enable only");
  chk_erase_needs_ee: assert property (@(posedge mclk) disable iff (!rst_n)
    flashErase |-> $past(eeOn) && $past(weOn))
    else $error("erase without both enables");
  chk_prog_data: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && op == PFC_OP_PROG |=> flashProg && flashData == $past(moveData)
      && flashAddr == $past(moveAddr))
    else $error("program strobe or data wrong");
  chk_erase_page: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && op == PFC_OP_ERASE |=> flashErase && flashData == 8'h00
      && flashAddr == pageBase($past(moveAddr)))
    else $error("erase strobe or page base wrong");
  chk_ram_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    accept && !weOn |=> ramWr && !flashProg && !flashErase
      && ramData == $past(moveData))
    else $error("move write not passed to ram");
  chk_no_ram_flash: assert property (@(posedge mclk) disable iff (!rst_n)
    ramWr |-> !$past(weOn))
    else $error("ram write while flash writes enabled");
  chk_erase_data_free: assert property (@(posedge mclk) disable iff (!rst_n)
    flashErase |-> flashData == 8'h00)
    else $error("erase carried a data byte");
  chk_reg_readback: assert property (@(posedge mclk) disable iff (!rst_n)
    sfrRd && ctrlSel |-> sfrRdata[7:2] == 6'h00 && sfrRdata[1:0] == ctrl)
    else $error("control readback wrong");
  chk_busy_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    flashProg |-> busy [*5] ##1 !busy)
    else $error("program busy length wrong");

  cov_prog: cover property (@(posedge mclk) disable iff (!rst_n) flashProg);
  cov_erase: cover property (@(posedge mclk) disable iff (!rst_n) flashErase);
  cov_ram: cover property (@(posedge mclk) disable iff (!rst_n) ramWr);
  cov_stall: cover property (@(posedge mclk) disable iff (!rst_n) moveStall);
endmodule

// [core/pfc_pkg.sv]
// package: register map, fields and timing for the program flash write/erase control
package pfc_pkg;
  localparam logic [7:0] PFC_CTRL_ADDR = 8'h8F;
  localparam logic [7:0] PFC_CTRL_RESET = 8'h00;
  localparam int PFC_WE_BIT = 0;
  localparam int PFC_EE_BIT = 1;
  localparam int PFC_ADDR_W = 16;
  localparam int PFC_PAGE_BYTES = 512;
  localparam int PFC_PROG_NS = 40;
  localparam int PFC_ERASE_NS = 200;
  localparam int PFC_CLK_NS = 10;
  localparam int PFC_PROG_CYC = (PFC_PROG_NS + PFC_CLK_NS - 1) / PFC_CLK_NS;
  localparam int PFC_ERASE_CYC = (PFC_ERASE_NS + PFC_CLK_NS - 1) / PFC_CLK_NS;
  typedef enum logic [1:0] {PFC_OP_NONE, PFC_OP_PROG, PFC_OP_ERASE} pfc_op_t;
endpackage

// [core/pfc_flash_timer.sv]
// busy timer that holds a flash operation for its required number of cycles
`timescale 1ns/10ps
module pfc_flash_timer #(
  parameter int CNT_W = 8
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic start, // load pulse
  input wire logic [CNT_W-1:0] cycles, // cycles to run, at least one
  output logic busy // high while counting
);
  import pfc_pkg::*;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (start) begin
      next_count = cycles;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy = (count != '0);
endmodule

// [verif/pfc_core_model.sv]
// core model: issues move writes and holds each until the control block takes it
`timescale 1ns/10ps
module pfc_core_model (
  input wire logic mclk, // system clock
  input wire logic moveStall, // hold request while high
  output logic moveWr, // move write strobe
  output logic [15:0] moveAddr, // move address
  output logic [7:0] moveData, // move data
  output int stalls // cycles the last request waited
);
  initial begin
    moveWr = 0;
    moveAddr = 0;
    moveData = 0;
    stalls = 0;
  end
  // the model waits on the one system clock only until its move write is accepted
  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    moveWr <= 1;
    moveAddr <= a;
    moveData <= d;
    stalls = 0;
    @(negedge mclk);
    while (moveStall !== 1'b0 && stalls < 64) begin
      stalls++;
      @(negedge mclk);
    end
    @(posedge mclk);
    moveWr <= 0;
    // released lines must not keep showing the last value
    moveAddr <= ~a;
    moveData <= ~d;
  endtask
endmodule

// [verif/program_flash_write_erase_ctrl_tb.sv]
// testbench: register and move write traffic checked against a behavioural model
`timescale 1ns/10ps
module program_flash_write_erase_ctrl_tb;
  import pfc_pkg::*;
  logic mclk, rst_n, sfrWr, sfrRd, sfrHit, moveWr, moveStall, ramWr;
  logic flashProg, flashErase, flashBusy;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, moveData, ramData, flashData, d;
  logic [15:0] moveAddr, ramAddr, flashAddr, a;
  int stalls, n, fails = 0, compares = 0, ctrlM = 0;
  int unsigned rs = 8180;
  pfc_ctrl u_pfc_ctrl (.mclk, .rst_n, .sfrWr, .sfrRd, .sfrAddr, .sfrWdata, .sfrRdata, .sfrHit,
    .moveWr, .moveAddr, .moveData, .moveStall, .ramWr, .ramAddr, .ramData, .flashProg,
    .flashErase, .flashAddr, .flashData, .flashBusy);
  pfc_core_model u_pfc_core_model (.mclk, .moveStall, .moveWr, .moveAddr, .moveData, .stalls);
  function automatic logic [15:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[15:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic regWr(input logic [7:0] ad, input logic [7:0] v);
    sfrWr <= 1;
    sfrAddr <= ad;
    sfrWdata <= v;
    @(posedge mclk);
    sfrWr <= 0;
    if (ad == PFC_CTRL_ADDR) ctrlM = v & 3;
  endtask
  task automatic regRd(input logic [7:0] ad);
    sfrRd <= 1;
    sfrAddr <= ad;
    @(negedge mclk);
    chk("hit", 16'(ad == PFC_CTRL_ADDR), 16'(sfrHit));
    chk("rdata", ad == PFC_CTRL_ADDR ? 16'(ctrlM) : 0, 16'(sfrRdata));
    @(posedge mclk);
    sfrRd <= 0;
    // let an edge pass so a following read does not re-raise the strobe in this step
    @(posedge mclk);
  endtask
  task automatic doMove(input logic [15:0] ad, input logic [7:0] dv, input bit wt);
    u_pfc_core_model.mw(ad, dv);
    if (stalls >= 64) begin
      fails++;
      final_report();
    end
    @(negedge mclk);
    chk("ramWr", 16'(ctrlM[0] == 0), 16'(ramWr));
    chk("prog", 16'(ctrlM == 1), 16'(flashProg));
    chk("erase", 16'(ctrlM == 3), 16'(flashErase));
    if (ctrlM[0] == 0) begin
      chk("ramAddr", ad, ramAddr);
      chk("ramData", 16'(dv), 16'(ramData));
    end else begin
      chk("fAddr", ctrlM == 3 ? ad & ~16'(PFC_PAGE_BYTES - 1) : ad, flashAddr);
      chk("fData", ctrlM == 3 ? 0 : 16'(dv), 16'(flashData));
      n = 0;
      while (wt && flashBusy === 1'b1 && n < 64) begin
        n++;
        @(negedge mclk);
      end
      if (wt) chk("busy", 16'(ctrlM == 3 ? PFC_ERASE_CYC + 1 : PFC_PROG_CYC + 1), 16'(n));
    end
    @(posedge mclk);
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_n = 0;
    sfrWr = 0;
    sfrRd = 0;
    sfrAddr = 0;
    sfrWdata = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    @(posedge mclk);
    regRd(PFC_CTRL_ADDR);
    regWr(8'h8E, 8'hFF);
    regRd(8'h8E);
    regRd(PFC_CTRL_ADDR);
    // every enable combination, upper bits written with noise
    for (int c = 0; c < 4; c++) begin
      regWr(PFC_CTRL_ADDR, (8'(xs()) & 8'hFC) | 8'(c));
      regRd(PFC_CTRL_ADDR);
      a = xs();
      d = 8'(xs());
      doMove(a, d, 1);
      doMove(a, ~d, 1);
    end
    // page was just erased, so program it back to back
    regWr(PFC_CTRL_ADDR, 8'h01);
    doMove(a, d, 0);
    doMove(a + 16'h0001, ~d, 0);
    chk("stall", 16'(PFC_PROG_CYC), 16'(stalls));
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    ctrlM = 0;
    @(posedge mclk);
    regRd(PFC_CTRL_ADDR);
    doMove(xs(), 8'(xs()), 1);
    final_report();
  end
endmodule
